/* include/uitc_pkg.sv */
// Package for the upstream traffic class mapping control block.
// Assumes a 32-bit word-wide register port on the device control window.
package uitc_pkg;

    // Register byte offsets in the device control window
    localparam logic [7:0] UITC_OFF_IDENT = 8'h00;
    localparam logic [7:0] UITC_OFF_ARB_CTRL = 8'h04;
    localparam logic [7:0] UITC_OFF_WIN0_CTRL = 8'h08;
    localparam logic [7:0] UITC_OFF_WIN0_BASE = 8'h0C;
    localparam logic [7:0] UITC_OFF_WIN0_LIMIT = 8'h10;

    // Arbiter control fields
    localparam int UITC_ARB_MAP_EN_BIT = 0;
    localparam int UITC_ARB_TABLE_EN_BIT = 1;
    localparam int UITC_ARB_AGGR_EN_BIT = 2;
    localparam logic [15:0] UITC_ARB_CTRL_RESET = 16'h0000;

    // Window control fields
    localparam int UITC_WIN_EN_BIT = 0;
    localparam int UITC_WIN_CLASS_LSB = 1;
    localparam int UITC_WIN_CLASS_MSB = 3;
    localparam logic [2:0] UITC_WIN_CLASS_RESET = 3'h0;
    localparam logic [31:0] UITC_WIN_ADDR_RESET = 32'h0000_0000;

    // Identification word fields
    localparam int UITC_IDENT_REV_LSB = 8;
    localparam int UITC_IDENT_CAP_LSB = 16;
    localparam logic [3:0] UITC_WINDOW_COUNT = 4'h4;

    // Default traffic class
    localparam logic [2:0] UITC_CLASS_ZERO = 3'h0;

    // Number of secondary bus masters
    localparam int UITC_MASTERS = 8;

    // Reset sources: hot, fundamental, global
    localparam int UITC_RESET_SOURCES = 3;

    typedef enum logic [1:0]
    {
        UITC_ARB_CLASSIC,
        UITC_ARB_TABLE,
        UITC_ARB_AGGRESSIVE
    } uitc_arb_mode_type;

endpackage

/* core/uitc_sync3.sv */
// Three-stage synchroniser with agreement filter, one lane per bit.
// Assumes asynchronous level inputs and a single system clock.
`timescale 1ns/1ns
`default_nettype none

module uitc_sync3
#(
    parameter int WIDTH = 1
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Raw and filtered levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] level_out
);

    ////////////////////////////////////////////////////////////////////////
    genvar lane;
    generate
        for (lane = 0; lane < WIDTH; lane++)
        begin : g_lane
            logic stage1_q;
            logic stage2_q;
            logic stage3_q;
            logic level_q;

            always_ff @(posedge clk_sys)
            begin
                if (rst)
                begin
                    stage1_q <= 1'b0;
                    stage2_q <= 1'b0;
                    stage3_q <= 1'b0;
                end
                else
                begin
                    stage1_q <= async_in[lane];
                    stage2_q <= stage1_q;
                    stage3_q <= stage2_q;
                end
            end

            // A change counts only once the last two stages agree
            always_ff @(posedge clk_sys)
            begin
                if (rst)
                begin
                    level_q <= 1'b0;
                end
                else if (stage2_q == stage3_q)
                begin
                    level_q <= stage3_q;
                end
            end

            assign level_out[lane] = level_q;
        end
    endgenerate

endmodule

`default_nettype wire

/* core/uitc_ctrl.sv */
// Upstream traffic class mapping and secondary arbiter mode control.
// Assumes a simple register port from the device control window decoder,
// reset requests arriving asynchronously, and arbiters that supply their
// own grant proposals on the system clock.
//
// Summary of operation
// - Bits 15 to 3 of the arbiter control register read as zero and ignore writes.
// - With the global mapping enable clear, every upstream transfer gets class zero.
// - With table arbitration clear, grants follow only the classic arbiter settings.
// - With table arbitration set, grants follow the port arbitration table and ignore classic settings.
// - The aggressive bit is read-only zero while table arbitration is clear.
// - With the aggressive bit clear, the arbiter acts as table arbitration alone dictates.
// - With the aggressive bit set, masters are stopped mid-transfer when isochronous service needs it.
// - Bits 15 to 4 of the window control register read as zero and ignore writes.
// - Bits 3 to 1 of the window control register hold a class, reset to zero, given to window hits.
// - A clear window enable leaves traffic untouched; a set one maps hits to the window class.
// - The window base register is 32 bits read/write, resets to zero, and is scratch when disabled.
// - The window limit register is 32 bits read/write at offset 10h and bounds the window.
// - The capability field reports four windows as 0100b and is read-only.
// - All registers clear on hot reset, fundamental reset, global reset and power-on reset.
`timescale 1ns/1ns
`default_nettype none

module uitc_ctrl
    import uitc_pkg::*;
#(
    // Arbitrary identification values
    parameter logic [7:0] MAP_IDENT = 8'h5A,
    parameter logic [7:0] MAP_REVISION = 8'h00
)
(
    // Clock and power-on reset
    input wire logic clk_sys,
    input wire logic rst,
    // Further reset requests, asynchronous
    input wire logic link_hot_reset,
    input wire logic fundamental_link_reset,
    input wire logic global_reset,
    // Register port
    input wire logic reg_req,
    input wire logic reg_write,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic reg_ack,
    output logic [31:0] reg_rdata,
    // Upstream transfer classification
    input wire logic us_valid,
    input wire logic [31:0] us_addr,
    output logic us_class_valid,
    output logic [2:0] us_class,
    output logic us_window_hit,
    // Secondary bus arbiter
    input wire logic [UITC_MASTERS-1:0] classic_grant,
    input wire logic [UITC_MASTERS-1:0] table_grant,
    input wire logic iso_service_due,
    input wire logic bus_busy,
    output logic [UITC_MASTERS-1:0] master_grant,
    output logic master_stop,
    output uitc_arb_mode_type arb_mode
);

    ////////////////////////////////////////////////////////////////////////
    // Reset gathering

    logic [UITC_RESET_SOURCES-1:0] reset_req_level;
    logic clear_all;

    uitc_sync3
    #(
        .WIDTH(UITC_RESET_SOURCES)
    )
    u_reset_sync
    (
        .clk_sys(clk_sys),
        .rst(rst),
        .async_in({global_reset, fundamental_link_reset, link_hot_reset}),
        .level_out(reset_req_level)
    );

    // Power-on reset and every filtered request clear the same registers
    assign clear_all = rst | (|reset_req_level);

    ////////////////////////////////////////////////////////////////////////
    // Register decode

    logic wr_arb_ctrl;
    logic wr_win0_ctrl;
    logic wr_win0_base;
    logic wr_win0_limit;

    always_comb
    begin
        wr_arb_ctrl = 1'b0;
        wr_win0_ctrl = 1'b0;
        wr_win0_base = 1'b0;
        wr_win0_limit = 1'b0;
        if (reg_req && reg_write)
        begin
            if (reg_addr == UITC_OFF_ARB_CTRL)
            begin
                wr_arb_ctrl = 1'b1;
            end
            else if (reg_addr == UITC_OFF_WIN0_CTRL)
            begin
                wr_win0_ctrl = 1'b1;
            end
            else if (reg_addr == UITC_OFF_WIN0_BASE)
            begin
                wr_win0_base = 1'b1;
            end
            else if (reg_addr == UITC_OFF_WIN0_LIMIT)
            begin
                wr_win0_limit = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Arbiter control register

    logic map_enable_q;
    logic table_enable_q;
    logic aggressive_enable_q;

    always_ff @(posedge clk_sys)
    begin
        if (clear_all)
        begin
            map_enable_q <= UITC_ARB_CTRL_RESET[UITC_ARB_MAP_EN_BIT];
            table_enable_q <= UITC_ARB_CTRL_RESET[UITC_ARB_TABLE_EN_BIT];
            aggressive_enable_q <= UITC_ARB_CTRL_RESET[UITC_ARB_AGGR_EN_BIT];
        end
        else if (wr_arb_ctrl)
        begin
            // Upper bits have no storage, so writes to them vanish
            map_enable_q <= reg_wdata[UITC_ARB_MAP_EN_BIT];
            table_enable_q <= reg_wdata[UITC_ARB_TABLE_EN_BIT];
            // Aggressive bit only sticks alongside table arbitration
            aggressive_enable_q <= reg_wdata[UITC_ARB_AGGR_EN_BIT] & reg_wdata[UITC_ARB_TABLE_EN_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Window 0 registers

    logic win0_enable_q;
    logic [2:0] win0_class_q;
    logic [31:0] win0_base_q;
    logic [31:0] win0_limit_q;

    always_ff @(posedge clk_sys)
    begin
        if (clear_all)
        begin
            win0_enable_q <= 1'b0;
            win0_class_q <= UITC_WIN_CLASS_RESET;
        end
        else if (wr_win0_ctrl)
        begin
            win0_enable_q <= reg_wdata[UITC_WIN_EN_BIT];
            win0_class_q <= reg_wdata[UITC_WIN_CLASS_MSB:UITC_WIN_CLASS_LSB];
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (clear_all)
        begin
            win0_base_q <= UITC_WIN_ADDR_RESET;
            win0_limit_q <= UITC_WIN_ADDR_RESET;
        end
        else if (wr_win0_base)
        begin
            win0_base_q <= reg_wdata;
        end
        else if (wr_win0_limit)
        begin
            win0_limit_q <= reg_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register read-back

    logic [31:0] read_value;

    always_comb
    begin
        read_value = 32'h0000_0000;
        if (reg_addr == UITC_OFF_IDENT)
        begin
            read_value[7:0] = MAP_IDENT;
            read_value[UITC_IDENT_REV_LSB +: 8] = MAP_REVISION;
            read_value[UITC_IDENT_CAP_LSB +: 4] = UITC_WINDOW_COUNT;
        end
        else if (reg_addr == UITC_OFF_ARB_CTRL)
        begin
            // Reserved bits stay zero from the default above
            read_value[UITC_ARB_MAP_EN_BIT] = map_enable_q;
            read_value[UITC_ARB_TABLE_EN_BIT] = table_enable_q;
            read_value[UITC_ARB_AGGR_EN_BIT] = aggressive_enable_q & table_enable_q;
        end
        else if (reg_addr == UITC_OFF_WIN0_CTRL)
        begin
            read_value[UITC_WIN_EN_BIT] = win0_enable_q;
            read_value[UITC_WIN_CLASS_MSB:UITC_WIN_CLASS_LSB] = win0_class_q;
        end
        else if (reg_addr == UITC_OFF_WIN0_BASE)
        begin
            read_value = win0_base_q;
        end
        else if (reg_addr == UITC_OFF_WIN0_LIMIT)
        begin
            read_value = win0_limit_q;
        end
    end

    // Every request is answered one cycle later, unmapped reads with zero
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            reg_ack <= 1'b0;
            reg_rdata <= 32'h0000_0000;
        end
        else
        begin
            reg_ack <= reg_req;
            if (reg_req && !reg_write)
            begin
                reg_rdata <= read_value;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Upstream classification

    logic win0_hit;

    // Both bounds inclusive; an inverted window simply never hits
    assign win0_hit = map_enable_q && win0_enable_q
        && (us_addr >= win0_base_q) && (us_addr <= win0_limit_q);

    always_ff @(posedge clk_sys)
    begin
        if (clear_all)
        begin
            us_class_valid <= 1'b0;
            us_class <= UITC_CLASS_ZERO;
            us_window_hit <= 1'b0;
        end
        else
        begin
            us_class_valid <= us_valid;
            if (us_valid)
            begin
                us_window_hit <= win0_hit;
                if (win0_hit)
                begin
                    us_class <= win0_class_q;
                end
                else
                begin
                    // Misses and disabled mapping fall back to class zero
                    us_class <= UITC_CLASS_ZERO;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Arbiter mode and grant steering

    uitc_arb_mode_type mode_d;

    always_comb
    begin
        if (!table_enable_q)
        begin
            mode_d = UITC_ARB_CLASSIC;
        end
        else if (aggressive_enable_q)
        begin
            mode_d = UITC_ARB_AGGRESSIVE;
        end
        else
        begin
            mode_d = UITC_ARB_TABLE;
        end
    end

    // Grants are registered to keep the steering mux off the bus timing path
    always_ff @(posedge clk_sys)
    begin
        if (clear_all)
        begin
            arb_mode <= UITC_ARB_CLASSIC;
            master_grant <= '0;
            master_stop <= 1'b0;
        end
        else
        begin
            arb_mode <= mode_d;
            case (mode_d)
                UITC_ARB_CLASSIC:
                begin
                    master_grant <= classic_grant;
                    master_stop <= 1'b0;
                end
                UITC_ARB_TABLE:
                begin
                    master_grant <= table_grant;
                    master_stop <= 1'b0;
                end
                UITC_ARB_AGGRESSIVE:
                begin
                    master_grant <= table_grant;
                    master_stop <= iso_service_due & bus_busy;
                end
                default:
                begin
                    master_grant <= classic_grant;
                    master_stop <= 1'b0;
                end
            endcase
        end
    end

endmodule

`default_nettype wire

/* tb/uitc_ctrl_properties.sv */
// Concurrent checks on the ports of the traffic class mapping control block.
// Assumes one clock; all resets quiet the checks until their effect has passed.
`timescale 1ns/1ns
`default_nettype none

module uitc_ctrl_properties
    import uitc_pkg::*;
(
    // Clock and resets
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic link_hot_reset,
    input wire logic fundamental_link_reset,
    input wire logic global_reset,
    // Register port
    input wire logic reg_req,
    input wire logic reg_write,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_rdata,
    input wire logic reg_ack,
    // Classification
    input wire logic us_valid,
    input wire logic us_class_valid,
    input wire logic [2:0] us_class,
    input wire logic us_window_hit,
    // Arbiter
    input wire logic [UITC_MASTERS-1:0] classic_grant,
    input wire logic [UITC_MASTERS-1:0] table_grant,
    input wire logic iso_service_due,
    input wire logic bus_busy,
    input wire logic [UITC_MASTERS-1:0] master_grant,
    input wire logic master_stop,
    input wire uitc_arb_mode_type arb_mode
);

// Filtered resets act late, so the checks rest well past any reset level
logic [3:0] hold_q;
always_ff @(posedge clk_sys)
begin
    if (rst || link_hot_reset || fundamental_link_reset || global_reset)
        hold_q <= 4'hF;
    else if (hold_q != 4'h0)
        hold_q <= hold_q - 4'h1;
end

default clocking cb @(posedge clk_sys); endclocking
default disable iff (rst || hold_q != 4'h0);

sequence rd_arb;
    reg_req && !reg_write && reg_addr == UITC_OFF_ARB_CTRL;
endsequence
sequence rd_win;
    reg_req && !reg_write && reg_addr == UITC_OFF_WIN0_CTRL;
endsequence
sequence aggr_cause;
    arb_mode == UITC_ARB_AGGRESSIVE && $past(iso_service_due) && $past(bus_busy);
endsequence

////////////////////////////////////////////////////////////////////////////////
ack_follows_req_a: assert property (reg_req |=> reg_ack)
    else $error("register answer missing");
ack_no_spurious_a: assert property (!reg_req |=> !reg_ack)
    else $error("register answer without request");
arb_rsvd_zero_a: assert property (rd_arb |=> reg_rdata[15:3] == 13'h0000)
    else $error("arbiter control reserved bits set");
aggr_ro_zero_a: assert property (rd_arb |=> !(reg_rdata[2] && !reg_rdata[1]))
    else $error("aggressive bit read as one without table bit");
win_rsvd_zero_a: assert property (rd_win |=> reg_rdata[31:4] == 28'h0000000)
    else $error("window control reserved bits set");
class_answer_a: assert property (us_valid |=> us_class_valid)
    else $error("class answer missing");
miss_class_zero_a: assert property (us_class_valid && !us_window_hit |-> us_class == UITC_CLASS_ZERO)
    else $error("miss given nonzero class");
class_hold_a: assert property (!us_valid |=> $stable(us_class) && $stable(us_window_hit))
    else $error("class changed without transfer");
classic_grant_a: assert property (arb_mode == UITC_ARB_CLASSIC |-> master_grant == $past(classic_grant))
    else $error("classic mode grant differs");
table_grant_a: assert property (arb_mode != UITC_ARB_CLASSIC |-> master_grant == $past(table_grant))
    else $error("table mode grant differs");
stop_cause_a: assert property (master_stop |-> aggr_cause)
    else $error("stop without aggressive cause");
stop_given_a: assert property (aggr_cause |-> master_stop)
    else $error("stop missing in aggressive mode");

endmodule

bind uitc_ctrl uitc_ctrl_properties i_uitc_ctrl_properties (.clk_sys, .rst, .link_hot_reset,
    .fundamental_link_reset, .global_reset, .reg_req, .reg_write, .reg_addr, .reg_rdata, .reg_ack,
    .us_valid, .us_class_valid, .us_class, .us_window_hit, .classic_grant, .table_grant,
    .iso_service_due, .bus_busy, .master_grant, .master_stop, .arb_mode);

`default_nettype wire

/* tb/uitc_bus_masters.sv */
// Secondary bus masters: request vector turned into classic and table proposals.
// Assumes requests and bus activity come from the bench.
`timescale 1ns/1ns
`default_nettype none

module uitc_bus_masters
    import uitc_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Bench stimulus
    input wire logic [UITC_MASTERS-1:0] req,
    input wire logic busy_in,
    input wire logic iso_in,
    // Toward the bridge
    output logic [UITC_MASTERS-1:0] classic_grant,
    output logic [UITC_MASTERS-1:0] table_grant,
    output logic iso_service_due,
    output logic bus_busy
);

// Table slot walks every cycle, so table proposals are often empty
logic [2:0] slot_q;
always_ff @(posedge clk_sys)
begin
    if (rst)
        slot_q <= 3'h0;
    else
        slot_q <= slot_q + 3'h1;
end

assign classic_grant = req & (~req + UITC_MASTERS'(1));
assign table_grant = req & (UITC_MASTERS'(1) << slot_q);
assign iso_service_due = iso_in & ~slot_q[0];
assign bus_busy = busy_in & (|req);

endmodule

`default_nettype wire

/* tb/test_upstream_isoc_tc_mapping_control.sv */
// Self-checking bench for the traffic class mapping control block.
// Assumes the bus master model on the arbiter side and a 250 MHz clock.
`timescale 1ns/1ns
`default_nettype none

module test_upstream_isoc_tc_mapping_control
    import uitc_pkg::*;
;

logic clk_sys = 1'b0;
logic rst = 1'b1;
logic link_hot_reset = 1'b0, fundamental_link_reset = 1'b0, global_reset = 1'b0;
logic reg_req = 1'b0, reg_write = 1'b0, reg_ack, us_valid = 1'b0, us_class_valid, us_window_hit;
logic [7:0] reg_addr = 8'h00;
logic [31:0] reg_wdata = 32'h00000000, reg_rdata, us_addr = 32'h00000000;
logic [2:0] us_class;
logic [UITC_MASTERS-1:0] req = 8'h00, classic_grant, table_grant, master_grant;
logic busy_in = 1'b0, iso_in = 1'b0, iso_service_due, bus_busy, master_stop;
uitc_arb_mode_type arb_mode;
logic [31:0] seed = 32'h534A9755, q, arb_s, win_s, base_s, lim_s, e;
logic [UITC_MASTERS-1:0] cg, tg;
logic stop_e;
int error_cnt = 0, compares = 0;

always #2 clk_sys = ~clk_sys;

uitc_ctrl i_uitc_ctrl (.clk_sys, .rst, .link_hot_reset, .fundamental_link_reset, .global_reset,
    .reg_req, .reg_write, .reg_addr, .reg_wdata, .reg_ack, .reg_rdata, .us_valid, .us_addr,
    .us_class_valid, .us_class, .us_window_hit, .classic_grant, .table_grant, .iso_service_due,
    .bus_busy, .master_grant, .master_stop, .arb_mode);
uitc_bus_masters i_uitc_bus_masters (.clk_sys, .rst, .req, .busy_in, .iso_in, .classic_grant,
    .table_grant, .iso_service_due, .bus_busy);

////////////////////////////////////////////////////////////////////////////////
function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
endfunction

// Stored arbiter control: the aggressive bit only sticks beside the table bit
function automatic logic [31:0] arb_exp(input logic [31:0] d);
    return {29'h0, d[2] & d[1], d[1], d[0]};
endfunction

function automatic logic [1:0] mode_exp(input logic [31:0] a);
    return a[1] ? (a[2] ? 2'h2 : 2'h1) : 2'h0;
endfunction

// Returns hit in bit 3 and class in bits 2:0
function automatic logic [3:0] cls_exp(input logic [31:0] a);
    logic hit;
    hit = arb_s[0] & win_s[0] & (a >= base_s) & (a <= lim_s);
    return hit ? {1'b1, win_s[3:1]} : 4'h0;
endfunction

task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
        error_cnt++;
        $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
endtask

// One access, answer one cycle later, then an idle cycle
task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    reg_req = 1'b1;
    reg_write = w;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk_sys) #1;
    reg_req = 1'b0;
    chk("reg_ack", 32'(reg_ack), 32'h1);
    r = reg_rdata;
    @(posedge clk_sys) #1;
endtask

task automatic print_verdict();
    $display("checks %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
        $display("Finished cleanly");
    else
        $display("Finished with errors");
    $finish;
endtask

////////////////////////////////////////////////////////////////////////////////
initial
begin
    repeat (2) @(posedge clk_sys);
    #1 rst = 1'b0;
    for (int i = 1; i < 6; i++)
    begin
        acc(1'b0, 8'(i * 4), 32'h0, q);
        chk("reset value", q, 32'h0);
    end
    acc(1'b0, UITC_OFF_IDENT, 32'h0, q);
    chk("window count", 32'(q[19:16]), 32'h4);
    // Every mode bit pattern, arbiter traffic in each
    for (int v = 0; v < 8; v++)
    begin
        e = {rnd() & 32'hFFFFFFF8} | 32'(v);
        acc(1'b1, UITC_OFF_ARB_CTRL, e, q);
        acc(1'b0, UITC_OFF_ARB_CTRL, 32'h0, q);
        chk("arbiter control", q, arb_exp(e));
        chk("arb_mode", 32'(arb_mode), 32'(mode_exp(e)));
        for (int c = 0; c < 6; c++)
        begin
            e = rnd();
            req = e[7:0];
            busy_in = e[8] | (c == 0);
            iso_in = e[9] | (c == 0);
            #1;
            cg = classic_grant;
            tg = table_grant;
            stop_e = (mode_exp(arb_exp(32'(v))) == 2'h2) & iso_service_due & bus_busy;
            @(posedge clk_sys) #1;
            chk("master_grant", 32'(master_grant), 32'(v[1] ? tg : cg));
            chk("master_stop", 32'(master_stop), 32'(stop_e));
        end
    end
    // Window set-ups incl. mapping off, window off and an empty range
    for (int r = 0; r < 6; r++)
    begin
        arb_s = arb_exp(rnd() & 32'hFFFFFFFE | 32'(r != 1));
        win_s = (rnd() & 32'hFFFFFFFE) | 32'(r != 2);
        base_s = rnd();
        lim_s = (r == 5) ? base_s - 32'h1 : base_s + (rnd() & 32'h00000FFF);
        acc(1'b1, UITC_OFF_ARB_CTRL, arb_s, q);
        acc(1'b1, UITC_OFF_WIN0_CTRL, win_s, q);
        acc(1'b1, UITC_OFF_WIN0_BASE, base_s, q);
        acc(1'b1, UITC_OFF_WIN0_LIMIT, lim_s, q);
        acc(1'b0, UITC_OFF_WIN0_CTRL, 32'h0, q);
        chk("window control", q, win_s & 32'h0000000F);
        win_s = q;
        acc(1'b0, UITC_OFF_WIN0_BASE, 32'h0, q);
        chk("window base", q, base_s);
        acc(1'b0, UITC_OFF_WIN0_LIMIT, 32'h0, q);
        chk("window limit", q, lim_s);
        us_valid = 1'b1;
        for (int k = 0; k < 5; k++)
        begin
            us_addr = (k == 0) ? base_s - 32'h1 : (k == 1) ? base_s : (k == 2) ? lim_s :
                (k == 3) ? lim_s + 32'h1 : rnd();
            @(posedge clk_sys) #1;
            chk("us_class_valid", 32'(us_class_valid), 32'h1);
            chk("hit and class", 32'({us_window_hit, us_class}), 32'(cls_exp(us_addr)));
        end
        us_valid = 1'b0;
        @(posedge clk_sys) #1;
    end
    // Each further reset source clears the configuration
    for (int s = 0; s < 3; s++)
    begin
        acc(1'b1, UITC_OFF_ARB_CTRL, 32'h7, q);
        acc(1'b1, UITC_OFF_WIN0_CTRL, 32'hB, q);
        {global_reset, fundamental_link_reset, link_hot_reset} = 3'(1 << s);
        repeat (4) @(posedge clk_sys);
        #1 {global_reset, fundamental_link_reset, link_hot_reset} = 3'h0;
        repeat (8) @(posedge clk_sys);
        #1;
        acc(1'b0, UITC_OFF_ARB_CTRL, 32'h0, q);
        chk("arbiter after reset", q, 32'h0);
        acc(1'b0, UITC_OFF_WIN0_CTRL, 32'h0, q);
        chk("window after reset", q, 32'h0);
        acc(1'b0, UITC_OFF_WIN0_BASE, 32'h0, q);
        chk("base after reset", q, 32'h0);
    end
    print_verdict();
end

endmodule

`default_nettype wire
